// [logic/dmsp_params.svh]
`ifndef DMSP_PARAMS_SVH
`define DMSP_PARAMS_SVH

// register indices, byte address is four times the index
`define DMSP_IDX_ASYNC_MODE 16'hff70
`define DMSP_IDX_CSI_CTRL 16'hff72
`define DMSP_IDX_ASYNC_STATUS 16'hff73
`define DMSP_IDX_DATA 16'hff74
`define DMSP_IDX_BAUD_CTRL 16'hff75

// reset values
`define DMSP_RST_ASYNC_MODE 8'h00
`define DMSP_RST_CSI_CTRL 8'h00
`define DMSP_RST_TX_SHIFT 8'hff
`define DMSP_RST_BAUD_CTRL 8'h00

// async mode register fields
`define DMSP_AM_TX_EN 7
`define DMSP_AM_RX_EN 6
`define DMSP_AM_PAR_HI 5
`define DMSP_AM_PAR_LO 4
`define DMSP_AM_LEN8 3
`define DMSP_AM_STOP2 2

// clocked serial control fields
`define DMSP_CS_ENABLE 7
`define DMSP_CS_SS_USE 6
`define DMSP_CS_PHASE 3
`define DMSP_CS_LSB_FIRST 2
`define DMSP_CS_INT_CLK 1
`define DMSP_CS_POL 0

// baud control: bit 7 picks the external clock input, low bits divide
`define DMSP_BG_EXT 7

// status bits
`define DMSP_ST_OVERRUN 0
`define DMSP_ST_FRAMING 1
`define DMSP_ST_PARITY 2
`define DMSP_ST_TX_BUSY 3
`define DMSP_ST_RX_FULL 4

// oversampling ticks per asynchronous bit, and clocked word length
`define DMSP_TICKS_LAST 4'hf
`define DMSP_TICKS_MID 4'h7
`define DMSP_CSI_BITS 4'h8

`endif

// [logic/dmsp_pkg.sv]
package dmsp_pkg;

    typedef enum logic [4:0] {
        DMSP_TX_IDLE = 5'b00001,
        DMSP_TX_START = 5'b00010,
        DMSP_TX_DATA = 5'b00100,
        DMSP_TX_PAR = 5'b01000,
        DMSP_TX_STOP = 5'b10000
    } dmsp_tx_state_t;

    typedef enum logic [4:0] {
        DMSP_RX_IDLE = 5'b00001,
        DMSP_RX_START = 5'b00010,
        DMSP_RX_DATA = 5'b00100,
        DMSP_RX_PAR = 5'b01000,
        DMSP_RX_STOP = 5'b10000
    } dmsp_rx_state_t;

endpackage

// [logic/dmsp_top.sv]
`include "dmsp_params.svh"
// Overview of operation
// - stopped, asynchronous and clocked serial modes
// - start bit plus byte, full duplex
// - baud from internal divider or external clock
// - clocked mode shifts eight bits both ways
// - seven-bit length sends bits zero to six
// - writing transmit register starts transmission
// - transmit register write-only, reads give buffer
// - transmit register resets to all ones
// - receive shift register fills receive buffer
// - seven-bit receive clears buffer top bit
// - receive buffer read-only, writes go transmit
// - transmitter adds start, parity, stop bits
// - receiver flags parity and framing errors
// - clocked control register, resets zero, writable
// - bit seven enables clocked mode
// - slave select gates communication when used
// - phase bit picks output clock edge
// - first-bit select: msb or lsb first
// - clock source: pin input or internal
// - polarity bit picks clock idle level
// - async mode register, transmit/receive enables
module dmsp_top (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n_o,
    input wire logic slave_select_pin_i,
    input wire logic async_clock_input_i
);
    // byte address of a register index
    function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
        hit = (addr == {idx, 2'b00});
    endfunction
    logic [7:0] async_mode_register_r, clocked_serial_control_r, baud_generator_control_r;
    logic [7:0] transmit_shift_reg_r, receive_shift_reg_r, receive_buffer_reg_r;
    logic ovr_r, frm_r, par_r, rx_full_r, pready_r, pslverr_r;
    logic [31:0] prdata_r;
    logic [3:0] s1_r, s2_r, tx_tick_r, rx_tick_r, csi_cnt_r;
    logic sck_prev_r, asck_prev_r, tick_r, tx_line_r, rx_acc_r, csi_busy_r, sck_int_r, serial_out_r, sck_oe_n_r;
    logic [6:0] div_cnt_r;
    logic [2:0] tx_bit_r, rx_bit_r;
    dmsp_pkg::dmsp_tx_state_t tx_state_r;
    dmsp_pkg::dmsp_rx_state_t rx_state_r;
    // decoded bus access, one access cycle is waited before ready
    logic acc, wr, rd, map_hit;
    assign acc = psel_i & penable_i & ~pready_r;
    assign wr = acc & pwrite_i & pstrb_i[0];
    assign rd = acc & ~pwrite_i;
    assign map_hit = hit(paddr_i, `DMSP_IDX_ASYNC_MODE) | hit(paddr_i, `DMSP_IDX_CSI_CTRL)
        | hit(paddr_i, `DMSP_IDX_ASYNC_STATUS) | hit(paddr_i, `DMSP_IDX_DATA)
        | hit(paddr_i, `DMSP_IDX_BAUD_CTRL);
    // pin inputs: {async clock, select, serial clock, serial in}
    logic si, sck_ext, ss, asck;
    assign si = s2_r[0];
    assign sck_ext = s2_r[1];
    assign ss = s2_r[2];
    assign asck = s2_r[3];
    // mode decode
    logic csi_en, tx_en, rx_en, len8, stop2, int_clk, lsb_first, phase, idle_lvl, comm_en;
    logic [1:0] par_sel;
    assign csi_en = clocked_serial_control_r[`DMSP_CS_ENABLE];
    assign tx_en = async_mode_register_r[`DMSP_AM_TX_EN] & ~csi_en;
    assign rx_en = async_mode_register_r[`DMSP_AM_RX_EN] & ~csi_en;
    assign len8 = async_mode_register_r[`DMSP_AM_LEN8];
    assign stop2 = async_mode_register_r[`DMSP_AM_STOP2];
    assign par_sel = {async_mode_register_r[`DMSP_AM_PAR_HI], async_mode_register_r[`DMSP_AM_PAR_LO]};
    assign int_clk = clocked_serial_control_r[`DMSP_CS_INT_CLK];
    assign lsb_first = clocked_serial_control_r[`DMSP_CS_LSB_FIRST];
    assign phase = clocked_serial_control_r[`DMSP_CS_PHASE];
    assign idle_lvl = ~clocked_serial_control_r[`DMSP_CS_POL];
    assign comm_en = ~clocked_serial_control_r[`DMSP_CS_SS_USE] | ~ss;
    // clocked mode clock edges
    logic sck_eff, sck_rise, sck_fall, out_edge, smp_edge, csi_done;
    assign sck_eff = int_clk ? sck_int_r : sck_ext;
    assign sck_rise = sck_eff & ~sck_prev_r;
    assign sck_fall = ~sck_eff & sck_prev_r;
    assign out_edge = csi_busy_r & comm_en & (phase ? sck_rise : sck_fall);
    assign smp_edge = csi_busy_r & comm_en & (phase ? sck_fall : sck_rise);
    assign csi_done = csi_busy_r & (csi_cnt_r == `DMSP_CSI_BITS) & (sck_eff == idle_lvl);
    // async bit boundaries and received word
    logic tx_bound, rx_bound, rx_mid, rx_load, data_wr, rx_perr;
    logic [7:0] rx_word;
    assign tx_bound = tick_r & (tx_tick_r == `DMSP_TICKS_LAST);
    assign rx_bound = tick_r & (rx_tick_r == `DMSP_TICKS_LAST);
    assign rx_mid = tick_r & (rx_tick_r == `DMSP_TICKS_MID);
    assign data_wr = wr & hit(paddr_i, `DMSP_IDX_DATA);
    assign rx_word = len8 ? receive_shift_reg_r : {1'b0, receive_shift_reg_r[7:1]};
    assign rx_perr = par_sel[1] & ((rx_acc_r ^ si) == par_sel[0]);
    assign rx_load = (rx_state_r == dmsp_pkg::DMSP_RX_STOP) & rx_bound;
    // two-flop synchronisers plus edge history
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= 4'hf;
            s2_r <= 4'hf;
            sck_prev_r <= 1'b1;
            asck_prev_r <= 1'b1;
        end else begin
            s1_r <= {async_clock_input_i, slave_select_pin_i, serial_clock_pin_i, serial_in_pin_i};
            s2_r <= s1_r;
            sck_prev_r <= sck_eff;
            asck_prev_r <= asck;
        end
    end
    // configuration registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            async_mode_register_r <= `DMSP_RST_ASYNC_MODE;
            clocked_serial_control_r <= `DMSP_RST_CSI_CTRL;
            baud_generator_control_r <= `DMSP_RST_BAUD_CTRL;
        end else if (wr) begin
            if (hit(paddr_i, `DMSP_IDX_ASYNC_MODE)) begin
                async_mode_register_r <= {pwdata_i[7:2], 2'b00};
            end
            if (hit(paddr_i, `DMSP_IDX_CSI_CTRL)) begin
                clocked_serial_control_r <= pwdata_i[7:0];
            end
            if (hit(paddr_i, `DMSP_IDX_BAUD_CTRL)) begin
                baud_generator_control_r <= pwdata_i[7:0];
            end
        end
    end
    // bus answer: ready, read data, error on unmapped address
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= acc;
            pslverr_r <= acc & ~map_hit;
            prdata_r <= 32'h0000_0000;
            if (rd) begin
                if (hit(paddr_i, `DMSP_IDX_ASYNC_MODE)) begin
                    prdata_r <= {24'h00_0000, async_mode_register_r};
                end
                if (hit(paddr_i, `DMSP_IDX_CSI_CTRL)) begin
                    prdata_r <= {24'h00_0000, clocked_serial_control_r};
                end
                if (hit(paddr_i, `DMSP_IDX_BAUD_CTRL)) begin
                    prdata_r <= {24'h00_0000, baud_generator_control_r};
                end
                if (hit(paddr_i, `DMSP_IDX_DATA)) begin
                    prdata_r <= {24'h00_0000, receive_buffer_reg_r};
                end
                if (hit(paddr_i, `DMSP_IDX_ASYNC_STATUS)) begin
                    prdata_r <= {27'h000_0000, rx_full_r, (tx_state_r != dmsp_pkg::DMSP_TX_IDLE) | csi_busy_r,
                        par_r, frm_r, ovr_r};
                end
            end
        end
    end
    // baud tick from divided ref clock or divided external clock, idle when stopped
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt_r <= 7'h00;
            tick_r <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (!(tx_en | rx_en | csi_en)) begin
                div_cnt_r <= 7'h00;
            end else if (!baud_generator_control_r[`DMSP_BG_EXT] | (asck & ~asck_prev_r)) begin
                if (div_cnt_r == baud_generator_control_r[6:0]) begin
                    div_cnt_r <= 7'h00;
                    tick_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 7'h01;
                end
            end
        end
    end
    // transmit shift register: cpu load, clocked mode shifting
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_shift_reg_r <= `DMSP_RST_TX_SHIFT;
        end else if (data_wr) begin
            transmit_shift_reg_r <= pwdata_i[7:0];
        end else if (out_edge && csi_cnt_r != 4'h0 && csi_cnt_r != `DMSP_CSI_BITS) begin
            transmit_shift_reg_r <= lsb_first ? {1'b1, transmit_shift_reg_r[7:1]}
                : {transmit_shift_reg_r[6:0], 1'b1};
        end
    end
    // asynchronous transmitter framing
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state_r <= dmsp_pkg::DMSP_TX_IDLE;
            tx_tick_r <= 4'h0;
            tx_bit_r <= 3'h0;
            tx_line_r <= 1'b1;
        end else begin
            if (tick_r) begin
                tx_tick_r <= tx_tick_r + 4'h1;
            end
            case (tx_state_r)
                dmsp_pkg::DMSP_TX_IDLE: begin
                    tx_line_r <= 1'b1;
                    if (data_wr && tx_en) begin
                        tx_state_r <= dmsp_pkg::DMSP_TX_START;
                        tx_tick_r <= 4'h0;
                        tx_line_r <= 1'b0;
                    end
                end
                dmsp_pkg::DMSP_TX_START: begin
                    if (tx_bound) begin
                        tx_state_r <= dmsp_pkg::DMSP_TX_DATA;
                        tx_bit_r <= 3'h0;
                        tx_line_r <= transmit_shift_reg_r[0];
                    end
                end
                dmsp_pkg::DMSP_TX_DATA: begin
                    if (tx_bound) begin
                        if (tx_bit_r == (len8 ? 3'h7 : 3'h6)) begin
                            tx_bit_r <= 3'h0;
                            if (par_sel != 2'b00) begin
                                tx_state_r <= dmsp_pkg::DMSP_TX_PAR;
                                tx_line_r <= par_sel[1] & (^(len8 ? transmit_shift_reg_r
                                    : {1'b0, transmit_shift_reg_r[6:0]}) ^ ~par_sel[0]);
                            end else begin
                                tx_state_r <= dmsp_pkg::DMSP_TX_STOP;
                                tx_line_r <= 1'b1;
                            end
                        end else begin
                            tx_bit_r <= tx_bit_r + 3'h1;
                            tx_line_r <= transmit_shift_reg_r[tx_bit_r + 3'h1];
                        end
                    end
                end
                dmsp_pkg::DMSP_TX_PAR: begin
                    if (tx_bound) begin
                        tx_state_r <= dmsp_pkg::DMSP_TX_STOP;
                        tx_line_r <= 1'b1;
                    end
                end
                dmsp_pkg::DMSP_TX_STOP: begin
                    if (tx_bound) begin
                        if (stop2 && tx_bit_r == 3'h0) begin
                            tx_bit_r <= 3'h1;
                        end else begin
                            tx_state_r <= dmsp_pkg::DMSP_TX_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_r <= dmsp_pkg::DMSP_TX_IDLE;
                end
            endcase
        end
    end
    // asynchronous receiver, runs beside the transmitter
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_r <= dmsp_pkg::DMSP_RX_IDLE;
            rx_tick_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_acc_r <= 1'b0;
        end else begin
            if (tick_r) begin
                rx_tick_r <= rx_tick_r + 4'h1;
            end
            case (rx_state_r)
                dmsp_pkg::DMSP_RX_IDLE: begin
                    rx_tick_r <= 4'h0;
                    if (rx_en && !si) begin
                        rx_state_r <= dmsp_pkg::DMSP_RX_START;
                    end
                end
                dmsp_pkg::DMSP_RX_START: begin
                    if (rx_mid) begin
                        rx_tick_r <= 4'h0;
                        rx_bit_r <= 3'h0;
                        rx_acc_r <= 1'b0;
                        rx_state_r <= si ? dmsp_pkg::DMSP_RX_IDLE : dmsp_pkg::DMSP_RX_DATA;
                    end
                end
                dmsp_pkg::DMSP_RX_DATA: begin
                    if (rx_bound) begin
                        rx_acc_r <= rx_acc_r ^ si;
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == (len8 ? 3'h7 : 3'h6)) begin
                            rx_state_r <= (par_sel != 2'b00) ? dmsp_pkg::DMSP_RX_PAR : dmsp_pkg::DMSP_RX_STOP;
                        end
                    end
                end
                dmsp_pkg::DMSP_RX_PAR: begin
                    if (rx_bound) begin
                        rx_state_r <= dmsp_pkg::DMSP_RX_STOP;
                    end
                end
                dmsp_pkg::DMSP_RX_STOP: begin
                    if (rx_bound) begin
                        rx_state_r <= dmsp_pkg::DMSP_RX_IDLE;
                    end
                end
                default: begin
                    rx_state_r <= dmsp_pkg::DMSP_RX_IDLE;
                end
            endcase
        end
    end
    // receive shift register, shared by both modes
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            receive_shift_reg_r <= 8'h00;
        end else if (rx_state_r == dmsp_pkg::DMSP_RX_DATA && rx_bound) begin
            receive_shift_reg_r <= {si, receive_shift_reg_r[7:1]};
        end else if (smp_edge && csi_cnt_r != `DMSP_CSI_BITS) begin
            receive_shift_reg_r <= lsb_first ? {si, receive_shift_reg_r[7:1]}
                : {receive_shift_reg_r[6:0], si};
        end
    end
    // receive buffer and error flags, set wins over read clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            receive_buffer_reg_r <= 8'h00;
            rx_full_r <= 1'b0;
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
            par_r <= 1'b0;
        end else begin
            if (rd && hit(paddr_i, `DMSP_IDX_DATA)) begin
                rx_full_r <= 1'b0;
            end
            if (rd && hit(paddr_i, `DMSP_IDX_ASYNC_STATUS)) begin
                ovr_r <= 1'b0;
                frm_r <= 1'b0;
                par_r <= 1'b0;
            end
            if (rx_state_r == dmsp_pkg::DMSP_RX_PAR && rx_bound && rx_perr) begin
                par_r <= 1'b1;
            end
            if (rx_load || csi_done) begin
                receive_buffer_reg_r <= csi_done ? receive_shift_reg_r : rx_word;
                rx_full_r <= 1'b1;
                if (rx_full_r) begin
                    ovr_r <= 1'b1;
                end
                if (rx_load && !si) begin
                    frm_r <= 1'b1;
                end
            end
        end
    end
    // clocked mode transfer control and internal clock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            csi_busy_r <= 1'b0;
            csi_cnt_r <= 4'h0;
            sck_int_r <= 1'b1;
        end else begin
            if (!csi_busy_r) begin
                sck_int_r <= idle_lvl;
            end else if (comm_en && tick_r && !(csi_cnt_r == `DMSP_CSI_BITS && sck_int_r == idle_lvl)) begin
                sck_int_r <= ~sck_int_r;
            end
            if (data_wr && csi_en) begin
                csi_busy_r <= 1'b1;
                csi_cnt_r <= 4'h0;
            end else if (csi_done || !csi_en) begin
                csi_busy_r <= 1'b0;
            end else if (smp_edge && csi_cnt_r != `DMSP_CSI_BITS) begin
                csi_cnt_r <= csi_cnt_r + 4'h1;
            end
        end
    end
    // pin drivers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_out_r <= 1'b1;
            sck_oe_n_r <= 1'b1;
        end else begin
            serial_out_r <= csi_en ? (lsb_first ? transmit_shift_reg_r[0] : transmit_shift_reg_r[7]) : tx_line_r;
            sck_oe_n_r <= ~(csi_en & int_clk);
        end
    end
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign serial_out_pin_o = serial_out_r;
    assign serial_clock_pin_o = sck_int_r;
    assign serial_clock_pin_oe_n_o = sck_oe_n_r;
endmodule

// [tb/dmsp_assertions.sv]
`include "dmsp_params.svh"

module dmsp_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [17:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic serial_in_pin_i,
    input wire logic serial_out_pin_o,
    input wire logic serial_clock_pin_i,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_n_o,
    input wire logic slave_select_pin_i,
    input wire logic async_clock_input_i
);
    logic wr_take;
    logic tx_en_r;
    logic cs_en_r;
    // write accepted at this edge
    assign wr_take = psel_i && penable_i && !pready_o && pwrite_i && pstrb_i[0];
    // shadow of the transmit and clocked-mode enable bits
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_en_r <= 1'b0;
            cs_en_r <= 1'b0;
        end else begin
            if (wr_take && paddr_i == {`DMSP_IDX_ASYNC_MODE, 2'b00}) tx_en_r <= pwdata_i[7];
            if (wr_take && paddr_i == {`DMSP_IDX_CSI_CTRL, 2'b00}) cs_en_r <= pwdata_i[7];
        end
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    chk_ready_answer: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer one cycle after access");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    chk_rdata_quiet: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    chk_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_tx_start: assert property (wr_take && paddr_i == {`DMSP_IDX_DATA, 2'b00} && tx_en_r && !cs_en_r
        |-> ##[1:3] !serial_out_pin_o) else $error("no start bit after data write");
    chk_line_idle: assert property (!tx_en_r && !cs_en_r ##1 !tx_en_r && !cs_en_r |-> serial_out_pin_o)
        else $error("line not idle while stopped");
    chk_clk_undriven: assert property (!cs_en_r ##1 !cs_en_r |-> serial_clock_pin_oe_n_o)
        else $error("clock pin driven outside clocked mode");
endmodule

bind dmsp_top dmsp_assertions u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .serial_in_pin_i(serial_in_pin_i),
    .serial_out_pin_o(serial_out_pin_o), .serial_clock_pin_i(serial_clock_pin_i),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_n_o(serial_clock_pin_oe_n_o),
    .slave_select_pin_i(slave_select_pin_i), .async_clock_input_i(async_clock_input_i)
);

// [tb/dmsp_remote_uart.sv]
module dmsp_remote_uart (
    input wire logic ref_clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic [9:0] frame_o,
    output int frames_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // capture ten bits after each start bit, mid-bit, 16 cycles a bit
    initial begin
        line_o = 1'b1;
        frames_o = 0;
        frame_o = 10'h000;
        forever begin
            @(negedge line_i);
            repeat (8) @(posedge ref_clk_i);
            for (int i = 0; i < 10; i++) begin
                repeat (16) @(posedge ref_clk_i);
                frame_o[i] = line_i;
            end
            frames_o++;
        end
    end
    // send start bit then ten bits lsb first, line back to idle high
    task automatic send(input logic [9:0] bits);
        line_o <= 1'b0;
        repeat (16) @(posedge ref_clk_i);
        for (int i = 0; i < 10; i++) begin
            line_o <= bits[i];
            repeat (16) @(posedge ref_clk_i);
        end
        line_o <= 1'b1;
    endtask
endmodule

// [tb/testbench.sv]
`include "dmsp_params.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [17:0] AM = {`DMSP_IDX_ASYNC_MODE, 2'b00};
    localparam logic [17:0] CS = {`DMSP_IDX_CSI_CTRL, 2'b00};
    localparam logic [17:0] ST = {`DMSP_IDX_ASYNC_STATUS, 2'b00};
    localparam logic [17:0] DT = {`DMSP_IDX_DATA, 2'b00};
    localparam logic [17:0] BG = {`DMSP_IDX_BAUD_CTRL, 2'b00};
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, sin, sout, sck, sck_oe_n, ss, slv;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, q, xp;
    logic [9:0] frame;
    logic [7:0] d, got;
    int frames, err_total, checks;
    dmsp_top u_dut (
        .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .serial_in_pin_i(sin), .serial_out_pin_o(sout), .serial_clock_pin_i(1'b1),
        .serial_clock_pin_o(sck), .serial_clock_pin_oe_n_o(sck_oe_n), .slave_select_pin_i(ss),
        .async_clock_input_i(1'b0)
    );
    dmsp_remote_uart u_far (.ref_clk_i(clk), .line_i(sout), .line_o(sin), .frame_o(frame), .frames_o(frames));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, request held until ready seen at a rising edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // next data write only after the frame and its stop bits are out
    task automatic wait_frame(input int f);
        while (frames == f) @(posedge clk);
        repeat (24) @(posedge clk);
    endtask
    task automatic test_reset();
        apb(0, CS, 0); compare("csi ctrl reset", 32'h0, q);
        apb(0, AM, 0); compare("async mode reset", 32'h0, q);
        apb(0, 18'h0, 0); compare("unmapped error", 32'h1, {31'h0, slv});
    endtask
    task automatic test_tx();
        apb(1, BG, 0);
        for (int p = 0; p < 4; p++) begin
            d = 8'h5c + 8'(p);
            apb(1, AM, 32'hc8 | (p << 4));
            apb(1, DT, {24'h0, d});
            wait_frame(frames);
            xp = p == 0 ? {22'h0, 2'b11, d} : {22'h0, 1'b1, p == 3 ? ^d : p == 2 ? ~^d : 1'b0, d};
            compare("tx frame", xp, {22'h0, frame});
        end
        apb(1, AM, 32'h80);
        apb(1, DT, 32'h7f);
        wait_frame(frames);
        compare("tx seven bit", 32'h3ff, {22'h0, frame});
    endtask
    task automatic test_rx();
        apb(1, AM, 32'hf8);
        apb(0, ST, 0);
        u_far.send({2'b10, 8'h5a});
        repeat (30) @(posedge clk);
        apb(0, DT, 0); compare("rx byte", 32'h5a, q);
        u_far.send({2'b11, 8'h5a});
        repeat (30) @(posedge clk);
        apb(0, ST, 0); compare("rx parity flag", 32'h14, q);
        apb(1, AM, 32'hc0);
        u_far.send(10'h3ff);
        repeat (30) @(posedge clk);
        apb(0, DT, 0); compare("rx seven bit", 32'h7f, q);
    endtask
    task automatic test_clocked();
        apb(1, AM, 0);
        apb(1, BG, 32'h3);
        apb(1, CS, 32'h82);
        apb(1, DT, 32'h96);
        for (int i = 0; i < 8; i++) begin
            @(posedge sck);
            got = {got[6:0], sout};
        end
        compare("clocked out msb first", 32'h96, {24'h0, got});
        compare("clock pin driven", 32'h0, {31'h0, sck_oe_n});
        repeat (20) @(posedge clk);
        apb(0, DT, 0); compare("clocked in word", 32'hff, q);
        ss <= 1'b1;
        apb(1, CS, 32'hc2);
        apb(1, DT, 32'h5a);
        repeat (20) @(posedge clk);
        apb(0, ST, 0); compare("busy under select", 32'h8, q & 32'h8);
        compare("clock held by select", 32'h1, {31'h0, sck});
        ss <= 1'b0;
        repeat (100) @(posedge clk);
        apb(0, ST, 0); compare("done after select", 32'h0, q & 32'h8);
    endtask
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
    // main sequence
    initial begin
        {rst_n, psel, pen, pwr, ss, paddr, pwdata, got, err_total, checks} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_tx();
        test_rx();
        test_clocked();
        complete_run();
    end
endmodule
